//--- common/cpl_pkg.sv
// package for the cursor palette and color lookup register bank
`default_nettype none
package cpl_pkg;
    localparam logic [11:0] CPL_OFF_PAL1 = 12'h0A0;
    localparam logic [11:0] CPL_OFF_PAL1_LIVE = 12'h0A4;
    localparam logic [11:0] CPL_OFF_PAL2 = 12'h0A8;
    localparam logic [11:0] CPL_OFF_PAL2_LIVE = 12'h0AC;
    localparam logic [11:0] CPL_OFF_PAL3 = 12'h0B0;
    localparam logic [11:0] CPL_OFF_PAL3_LIVE = 12'h0B4;
    localparam logic [11:0] CPL_OFF_CURSOR_STATUS = 12'h084;
    localparam logic [11:0] CPL_OFF_CURSOR_POS = 12'h090;
    localparam logic [11:0] CPL_OFF_CTRL = 12'h0C0;
    localparam logic [11:0] CPL_OFF_COLOR_LOOKUP_TABLE_LO = 12'h400;
    localparam logic [11:0] CPL_OFF_COLOR_LOOKUP_TABLE_HI = 12'h7FC;
    localparam int CPL_PENDING_BIT = 31;
    localparam int CPL_RED_LSB = 16;
    localparam int CPL_GREEN_LSB = 8;
    localparam int CPL_BLUE_LSB = 0;
    localparam int CPL_LUT_RED_LSB = 20;
    localparam int CPL_LUT_GREEN_LSB = 10;
    localparam int CPL_LUT_BLUE_LSB = 0;
    localparam int CPL_LUT_DEPTH = 256;
    localparam int CPL_CTRL_LUT_EN_BIT = 0;
    localparam int CPL_CTRL_MODE_LSB = 1;
    localparam logic [23:0] CPL_COLOR_RESET = 24'h000000;
    localparam logic [31:0] CPL_CTRL_RESET = 32'h00000000;

    typedef enum logic [1:0] {
        CPL_MODE_8BPP,
        CPL_MODE_16BPP,
        CPL_MODE_24BPP
    } cpl_mode_t;

    typedef struct packed {
        logic [7:0] red;
        logic [7:0] green;
        logic [7:0] blue;
    } cpl_color_t;

    typedef struct packed {
        logic [9:0] red;
        logic [9:0] green;
        logic [9:0] blue;
    } cpl_level_t;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } cpl_apb_req_t;
endpackage : cpl_pkg
`default_nettype wire

//--- rtl/cpl_bank.sv
// cursor palette staging, live colors and color lookup table with apb access
//
// Register access over APB was left to the implementer.
`default_nettype none
module cpl_bank (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // display engine status, from pins
    input wire logic vblank,
    input wire logic display_engine_running_flag,
    // cursor pixel in and mapped color out
    input wire logic [1:0] cursor_index,
    output logic [29:0] cursor_out,
    output logic cursor_out_valid
);
    import cpl_pkg::*;

    cpl_apb_req_t req;
    logic vblank_s1, vblank_s2, vblank_s3;
    logic run_s1, run_s2;
    logic cursor_update_pending;
    cpl_color_t staged [1:3];
    cpl_color_t live [1:3];
    logic [31:0] ctrl;
    logic [29:0] color_lookup_table [0:CPL_LUT_DEPTH-1];
    logic wr_en, rd_en, vblank_rise, stopped, lut_hit, known;
    logic [7:0] lut_idx;
    logic [29:0] lut_rdata;
    logic [31:0] next_prdata;
    logic [7:0] idx_r, idx_g, idx_b;
    cpl_color_t sel_color, trim_color;
    cpl_mode_t mode;
    logic [29:0] next_cursor_out;

    assign req = '{psel: psel, penable: penable, pwrite: pwrite, paddr: paddr, pwdata: pwdata};
    assign wr_en = clk_en && req.psel && req.penable && req.pwrite;
    assign rd_en = clk_en && req.psel && !req.penable && !req.pwrite;
    assign vblank_rise = vblank_s2 && !vblank_s3;
    assign stopped = !run_s2;
    // table spans 400h..7FCh, one word per index
    assign lut_hit = (req.paddr >= CPL_OFF_COLOR_LOOKUP_TABLE_LO) && (req.paddr <= CPL_OFF_COLOR_LOOKUP_TABLE_HI);
    assign lut_idx = req.paddr[9:2];
    assign mode = cpl_mode_t'(ctrl[CPL_CTRL_MODE_LSB +: 2]);

    // pins come from the display clock domain
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            vblank_s1 <= 1'b0;
            vblank_s2 <= 1'b0;
            vblank_s3 <= 1'b0;
            run_s1 <= 1'b0;
            run_s2 <= 1'b0;
        end else if (clk_en) begin
            vblank_s1 <= vblank;
            vblank_s2 <= vblank_s1;
            vblank_s3 <= vblank_s2;
            run_s1 <= display_engine_running_flag;
            run_s2 <= run_s1;
        end
    end

    // pending flag: set by position write while the engine runs, cleared by vblank or write-one
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cursor_update_pending <= 1'b0;
        end else if (clk_en) begin
            if (wr_en && req.paddr == CPL_OFF_CURSOR_POS) begin
                cursor_update_pending <= !stopped;
            end else if (vblank_rise && cursor_update_pending) begin
                cursor_update_pending <= 1'b0;
            end else if (wr_en && req.paddr == CPL_OFF_CURSOR_STATUS && req.pwdata[CPL_PENDING_BIT]) begin
                cursor_update_pending <= 1'b0;
            end
        end
    end

    // staging and live palettes, one pair per cursor color
    for (genvar i = 1; i <= 3; i++) begin : g_pal
        localparam logic [11:0] STAGE_OFF = CPL_OFF_PAL1 + 12'(8 * (i - 1));
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                staged[i] <= CPL_COLOR_RESET;
                live[i] <= CPL_COLOR_RESET;
            end else if (clk_en) begin
                if (wr_en && req.paddr == STAGE_OFF) begin
                    staged[i] <= req.pwdata[23:0];
                end
                if (wr_en && req.paddr == STAGE_OFF && stopped) begin
                    live[i] <= req.pwdata[23:0];
                end else if (vblank_rise && cursor_update_pending) begin
                    live[i] <= staged[i];
                end
            end
        end
    end

    // control register: lookup enable and pixel mode
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= CPL_CTRL_RESET;
        end else if (clk_en && wr_en && req.paddr == CPL_OFF_CTRL) begin
            ctrl <= {29'h0, req.pwdata[2:0]};
        end
    end

    // table has no reset; contents are undefined until software loads them
    always_ff @(posedge pclk) begin
        if (clk_en && wr_en && lut_hit) begin
            color_lookup_table[lut_idx] <= req.pwdata[29:0];
        end
    end

    assign lut_rdata = color_lookup_table[lut_idx];

    // read mux, captured in setup so prdata is a flop in the access phase
    always_comb begin
        next_prdata = 32'h00000000;
        known = 1'b1;
        if (lut_hit) begin
            next_prdata = {2'b00, lut_rdata};
        end else begin
            unique case (req.paddr)
                CPL_OFF_PAL1: next_prdata = {8'h00, staged[1]};
                CPL_OFF_PAL2: next_prdata = {8'h00, staged[2]};
                CPL_OFF_PAL3: next_prdata = {8'h00, staged[3]};
                CPL_OFF_PAL1_LIVE: next_prdata = {8'h00, live[1]};
                CPL_OFF_PAL2_LIVE: next_prdata = {8'h00, live[2]};
                CPL_OFF_PAL3_LIVE: next_prdata = {8'h00, live[3]};
                CPL_OFF_CURSOR_STATUS: next_prdata = {cursor_update_pending, 31'h0};
                CPL_OFF_CURSOR_POS: next_prdata = 32'h00000000;
                CPL_OFF_CTRL: next_prdata = ctrl;
                default: known = 1'b0;
            endcase
        end
    end

    // zero-wait slave; unmapped addresses answer with pslverr
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
            pslverr <= 1'b0;
            pready <= 1'b1;
        end else if (clk_en) begin
            pready <= 1'b1;
            if (req.psel && !req.penable) begin
                pslverr <= !known;
            end
            if (rd_en) begin
                prdata <= next_prdata;
            end
        end
    end

    // cursor pixel path: index 0 is transparent, 1..3 pick a palette entry
    always_comb begin
        sel_color = (cursor_index == 2'd0) ? CPL_COLOR_RESET : live[cursor_index];
        trim_color = sel_color;
        idx_r = sel_color.red;
        idx_g = sel_color.green;
        idx_b = sel_color.blue;
        unique case (mode)
            CPL_MODE_16BPP: begin
                trim_color = '{red: {3'b000, sel_color.red[4:0]}, green: {2'b00, sel_color.green[5:0]},
                               blue: {3'b000, sel_color.blue[4:0]}};
                idx_r = trim_color.red;
                idx_g = trim_color.green;
                idx_b = trim_color.blue;
            end
            CPL_MODE_8BPP: begin
                trim_color = '{red: sel_color.blue, green: sel_color.blue, blue: sel_color.blue};
                idx_r = sel_color.blue;
                idx_g = sel_color.blue;
                idx_b = sel_color.blue;
            end
            CPL_MODE_24BPP: begin
            end
            default: begin
            end
        endcase
    end

    // lookup path; one shared entry in 8-bit mode, one entry per channel otherwise
    always_comb begin
        if (ctrl[CPL_CTRL_LUT_EN_BIT]) begin
            if (mode == CPL_MODE_8BPP) begin
                next_cursor_out = color_lookup_table[idx_b];
            end else begin
                next_cursor_out = {color_lookup_table[idx_r][29:20],
                                   color_lookup_table[idx_g][19:10],
                                   color_lookup_table[idx_b][9:0]};
            end
        end else begin
            // without lookup the 8-bit value is widened by repeating its top bits
            next_cursor_out = {trim_color.red, trim_color.red[7:6], trim_color.green, trim_color.green[7:6],
                               trim_color.blue, trim_color.blue[7:6]};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cursor_out <= 30'h00000000;
            cursor_out_valid <= 1'b0;
        end else if (clk_en) begin
            // transparent pixels stay black even when the table would map index 0
            cursor_out <= (cursor_index != 2'd0) ? next_cursor_out : 30'h00000000;
            cursor_out_valid <= (cursor_index != 2'd0);
        end
    end
endmodule : cpl_bank
`default_nettype wire

//--- dv/cpl_bank_asserts.sv
// assertion checker for the cursor palette and color lookup bank
`default_nettype none
module cpl_bank_chk import cpl_pkg::*; (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // display and cursor
    input wire logic vblank,
    input wire logic display_engine_running_flag,
    input wire logic [1:0] cursor_index,
    input wire logic [29:0] cursor_out,
    input wire logic cursor_out_valid
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic rd_set;
    logic st_rd;
    // read data is loaded at the setup edge, so the checks look one cycle on
    assign rd_set = psel && !penable && !pwrite && clk_en;
    assign st_rd = rd_set && paddr == CPL_OFF_CURSOR_STATUS;
    a_blank_entry: assert property (clk_en && cursor_index == 2'h0 |=> !cursor_out_valid && cursor_out == 30'h0)
        else $error("transparent cursor pixel gave a color");
    a_entry_valid: assert property (clk_en && cursor_index != 2'h0 |=> cursor_out_valid)
        else $error("palette cursor pixel not flagged valid");
    a_pal_top: assert property (rd_set && paddr >= CPL_OFF_PAL1 && paddr <= CPL_OFF_PAL3_LIVE
        |=> prdata[31:24] == 8'h00 && !pslverr) else $error("palette top byte not zero");
    a_lut_top: assert property (rd_set && paddr >= CPL_OFF_COLOR_LOOKUP_TABLE_LO && paddr <= CPL_OFF_COLOR_LOOKUP_TABLE_HI
        |=> prdata[31:30] == 2'h0 && !pslverr) else $error("table top bits not zero");
    a_status_bits: assert property (st_rd |=> prdata[30:0] == 31'h0)
        else $error("status low bits not zero");
    a_pos_reads0: assert property (rd_set && paddr == CPL_OFF_CURSOR_POS |=> prdata == 32'h0)
        else $error("position register read not zero");
    a_cancel_pend: assert property (psel && penable && pwrite && clk_en && paddr == CPL_OFF_CURSOR_STATUS
        && pwdata[31] ##[1:2] st_rd |=> !prdata[31]) else $error("pending flag survived cancel");
    a_err_high: assert property (rd_set && paddr > CPL_OFF_COLOR_LOOKUP_TABLE_HI |=> pslverr && prdata == 32'h0)
        else $error("read past table not refused");
    cover property (psel && penable && pwrite && paddr == CPL_OFF_CURSOR_POS);
    cover property ($rose(vblank));
    cover property (cursor_out_valid ##1 !cursor_out_valid);
endmodule // cpl_bank_chk
bind cpl_bank cpl_bank_chk u_chk (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .vblank(vblank), .display_engine_running_flag(display_engine_running_flag),
    .cursor_index(cursor_index), .cursor_out(cursor_out), .cursor_out_valid(cursor_out_valid));
`default_nettype wire

//--- dv/test_cpl_bank.sv
// self-checking testbench for the cursor palette and color lookup bank
`default_nettype none
module test_cpl_bank import cpl_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, vblank = 1'b0, run = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, seed = 32'hCEFF;
    logic [1:0] cursor_index = 2'h0;
    logic [29:0] cursor_out;
    logic pready, pslverr, cursor_out_valid;
    logic [32:0] rq[$];
    logic [29:0] cq[$];
    logic [29:0] tbl[256];
    cpl_color_t live[4];
    logic [31:0] ctls[6] = '{32'h4, 32'h5, 32'h1, 32'h0, 32'h2, 32'h3};
    int err_total = 0, total_checks = 0;
    always #2 pclk = ~pclk;
    cpl_bank dut (.pclk(pclk), .presetn(presetn), .clk_en(1'b1), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .vblank(vblank), .display_engine_running_flag(run), .cursor_index(cursor_index),
        .cursor_out(cursor_out), .cursor_out_valid(cursor_out_valid));
    function logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    // no lookup widens 8 to 10 bits by repeating the top two
    function logic [29:0] mapc(input logic [31:0] ctl, input cpl_color_t c);
        cpl_color_t t;
        t = c;
        if (ctl[2:1] == 2'h1) t = '{red: {3'h0, c.red[4:0]}, green: {2'h0, c.green[5:0]}, blue: {3'h0, c.blue[4:0]}};
        if (ctl[2:1] == 2'h0) t = '{red: c.blue, green: c.blue, blue: c.blue};
        if (!ctl[0]) return {t.red, t.red[7:6], t.green, t.green[7:6], t.blue, t.blue[7:6]};
        if (ctl[2:1] == 2'h0) return tbl[t.blue];
        return {tbl[t.red][29:20], tbl[t.green][19:10], tbl[t.blue][9:0]};
    endfunction
    task conclude;
        err_total += rq.size() + cq.size();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task cmp_reg(input logic [32:0] e);
        total_checks++;
        if ({pslverr, prdata} !== e) begin
            err_total++;
            $display("BAD %0t reg got %h exp %h", $time, {pslverr, prdata}, e);
        end
    endtask
    task cmp_cur(input logic [29:0] e);
        total_checks++;
        if (cursor_out !== e) begin
            err_total++;
            $display("BAD %0t cursor got %h exp %h", $time, cursor_out, e);
        end
    endtask
    always @(posedge pclk) begin
        if (psel && penable && pready && !pwrite) cmp_reg(rq.pop_front());
        if (cursor_out_valid === 1'b1) cmp_cur(cq.pop_front());
    end
    // idle cycle after each transfer so psel is never assigned twice in one step
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [32:0] e);
        if (!w) rq.push_back(e);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk) penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 33'h0);
    endtask
    task rd(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0, {1'b0, e});
    endtask
    task vb;
        vblank <= 1'b1;
        repeat (4) @(posedge pclk);
        vblank <= 1'b0;
        repeat (6) @(posedge pclk);
    endtask
    task cur(input logic [1:0] i, input logic [29:0] e);
        cursor_index <= i;
        if (i != 2'h0) cq.push_back(e);
        @(posedge pclk);
    endtask
    initial begin
        repeat (20000) @(posedge pclk);
        err_total++;
        conclude;
    end
    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        for (int a = 'hA0; a <= 'hB4; a += 4) rd(12'(a), 32'h0);
        rd(CPL_OFF_CURSOR_STATUS, 32'h0);
        $display("test reset done");
        seed = lfsr(seed);
        wr(CPL_OFF_PAL1, seed);
        live[1] = seed[23:0];
        rd(CPL_OFF_PAL1, {8'h00, live[1]});
        rd(CPL_OFF_PAL1_LIVE, {8'h00, live[1]});
        wr(CPL_OFF_CURSOR_POS, 32'h0);
        rd(CPL_OFF_CURSOR_STATUS, 32'h0);
        $display("test stopped done");
        run <= 1'b1;
        repeat (4) @(posedge pclk);
        seed = lfsr(seed);
        live[2] = seed[23:0];
        live[3] = ~seed[23:0];
        wr(CPL_OFF_PAL2, seed);
        wr(CPL_OFF_PAL3, ~seed);
        rd(CPL_OFF_PAL2_LIVE, 32'h0);
        vb;
        rd(CPL_OFF_PAL3_LIVE, 32'h0);
        wr(CPL_OFF_CURSOR_POS, seed);
        rd(CPL_OFF_CURSOR_STATUS, 32'h80000000);
        vb;
        rd(CPL_OFF_PAL2_LIVE, {8'h00, live[2]});
        rd(CPL_OFF_PAL3_LIVE, {8'h00, live[3]});
        rd(CPL_OFF_CURSOR_STATUS, 32'h0);
        wr(CPL_OFF_CURSOR_POS, 32'h0);
        wr(CPL_OFF_CURSOR_STATUS, 32'h80000000);
        rd(CPL_OFF_CURSOR_STATUS, 32'h0);
        wr(CPL_OFF_PAL1, ~seed);
        vb;
        rd(CPL_OFF_PAL1_LIVE, {8'h00, live[1]});
        $display("test staging done");
        for (int i = 0; i < 256; i++) begin
            seed = lfsr(seed);
            tbl[i] = seed[29:0];
            wr(CPL_OFF_COLOR_LOOKUP_TABLE_LO + 12'(i * 4), seed);
        end
        rd(CPL_OFF_COLOR_LOOKUP_TABLE_LO, {2'h0, tbl[0]});
        rd(CPL_OFF_COLOR_LOOKUP_TABLE_HI, {2'h0, tbl[255]});
        apb(1'b0, 12'h800, 32'h0, {1'b1, 32'h0});
        $display("test table done");
        foreach (ctls[j]) begin
            wr(CPL_OFF_CTRL, ctls[j]);
            for (int k = 0; k < 4; k++) cur(2'(k), mapc(ctls[j], live[k]));
            cur(2'h0, 30'h0);
        end
        cur(2'h0, 30'h0);
        repeat (3) @(posedge pclk);
        $display("test cursor done");
        conclude;
    end
endmodule // test_cpl_bank
`default_nettype wire
